/* File: src/hp_regs.vh */
/*
 constants for the host port readout and crc check block.
 assumes inclusion by bare name from the design files under src/.
*/
`ifndef HP_REGS_VH
`define HP_REGS_VH
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define HP_CMD_CTRL_RD_BASE 8'h70
`define HP_CMD_CTRL_RD_MASK 8'hF1
`define HP_CMD_CRC_WR       8'hB6
`define HP_CMD_CRC_RD       8'hD6
// ----------------------------------------------------------------
// crc and readout layout
// ----------------------------------------------------------------
`define HP_CRC_POLY     16'h1021
`define HP_CRC_W        16
`define HP_CRC_RESET    16'h0000
`define HP_RO_W         24
`define HP_RO_LAST_BIT  5'h17
`define HP_RD_W         16
`define HP_CTRL_BANK_W  64
`define HP_DST_W        4
`define HP_DST_SO       4'h1
`endif

/* File: src/hp_crc16.v */
/*
 serial crc-16 remainder accumulator, msb first.
 assumes clr and shift_en are single-cycle pulses on clk.
*/
`timescale 1ns/1ps
`include "hp_regs.vh"
module hp_crc16
(
  input  wire                  clk,
  input  wire                  sys_rst,
  input  wire                  clr,
  input  wire                  shift_en,
  input  wire                  bit_in,
  output reg  [`HP_CRC_W-1:0]  crc
);
  // ----------------------------------------------------------------
  // remainder update
  // ----------------------------------------------------------------
  // feeding the top bit back equals dividing the message padded with 16 zeros
  wire                 fb       = crc[`HP_CRC_W-1] ^ bit_in;
  wire [`HP_CRC_W-1:0] next_crc = {crc[`HP_CRC_W-2:0], 1'b0} ^ (fb ? `HP_CRC_POLY : `HP_CRC_RESET);

  // clear wins over shift
  always @(posedge clk)
  begin
    if (sys_rst)
      crc <= `HP_CRC_RESET;
    else if (clr)
      crc <= `HP_CRC_RESET;
    else if (shift_en)
      crc <= next_crc;
  end
endmodule // hp_crc16

/* File: src/hp_port.v */
/*
 run-phase serial port readout and crc check of host traffic.
 assumes sclk, si and request_strobe_n come from the host pins, asynchronous
 to clk and far slower; the dsp side signals are on clk.
*/
`timescale 1ns/1ps
`include "hp_regs.vh"
module hp_port
(
  input  wire                        clk,
  input  wire                        sys_rst,
  input  wire                        sclk,
  input  wire                        si,
  input  wire                        request_strobe_n,
  input  wire [`HP_RO_W-1:0]         dsp_internal_bus,
  input  wire                        program_readout_instr,
  input  wire [`HP_DST_W-1:0]        destination_field,
  input  wire [`HP_CTRL_BANK_W-1:0]  ctrl_reg_bank,
  output reg                         so,
  output reg                         readout_data_valid,
  output reg  [`HP_CRC_W-1:0]        crc_expected_remainder,
  output reg                         crc_match
);
  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  reg  [2:0] pin_meta;
  reg  [2:0] pin_sync;
  reg  [2:0] pin_last;

  // two flops per pin, then one more stage for edge finding
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      pin_last <= 3'h7;
    end
    else
    begin
      pin_meta <= {request_strobe_n, si, sclk};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  wire sclk_s    = pin_sync[0];
  wire si_s      = pin_sync[1];
  wire rq_n_s    = pin_sync[2];
  wire sclk_rise = sclk_s & ~pin_last[0];
  wire sclk_fall = ~sclk_s & pin_last[0];
  wire rq_fall   = ~rq_n_s & pin_last[2];
  wire rq_rise   = rq_n_s & ~pin_last[2];
  wire rx_bit    = sclk_rise & ~rq_n_s;

  // ----------------------------------------------------------------
  // command byte receiver
  // ----------------------------------------------------------------
  reg  [2:0] bit_cnt;
  reg  [1:0] byte_cnt;
  reg  [6:0] rx_shift;
  reg  [7:0] cmd;
  reg  [7:0] exp_hi;
  reg  [`HP_RD_W-1:0] rd_shift;
  reg                 rd_load;
  reg                 rd_started;

  wire [7:0] rx_byte   = {rx_shift, si_s};
  wire       byte_done = rx_bit & (bit_cnt == 3'h7);
  wire       is_ctrl   = (rx_byte & `HP_CMD_CTRL_RD_MASK) == `HP_CMD_CTRL_RD_BASE;
  wire [7:0] ctrl_byte = ctrl_reg_bank[{rx_byte[3:1], 3'h0} +: 8];

  // bytes assemble msb first; first byte of a strobe is the command
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      bit_cnt                <= 3'h0;
      byte_cnt               <= 2'h0;
      rx_shift               <= 7'h00;
      cmd                    <= 8'h00;
      exp_hi                 <= 8'h00;
      crc_expected_remainder <= `HP_CRC_RESET;
      rd_shift               <= 16'h0000;
      rd_load                <= 1'b0;
    end
    else if (rq_fall)
    begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 2'h0;
      rd_load  <= 1'b0;
    end
    else if (rq_rise)
      rd_load <= 1'b0;
    else if (rx_bit)
    begin
      rx_shift <= rx_byte[6:0];
      bit_cnt  <= bit_cnt + 3'h1;
      if (byte_done)
      begin
        if (byte_cnt != 2'h3)
          byte_cnt <= byte_cnt + 2'h1;
        if (byte_cnt == 2'h0)
        begin
          cmd <= rx_byte;
          if (is_ctrl)
          begin
            rd_shift <= {ctrl_byte, 8'h00};
            rd_load  <= 1'b1;
          end
          else if (rx_byte == `HP_CMD_CRC_RD)
          begin
            rd_shift <= crc_expected_remainder;
            rd_load  <= 1'b1;
          end
        end
        else if (cmd == `HP_CMD_CRC_WR && byte_cnt == 2'h1)
          exp_hi <= rx_byte;
        else if (cmd == `HP_CMD_CRC_WR && byte_cnt == 2'h2)
          crc_expected_remainder <= {exp_hi, rx_byte};
      end
    end
    else if (sclk_fall && rd_started)
      rd_shift <= {rd_shift[`HP_RD_W-2:0], 1'b0};
  end

  // first falling edge after the command presents the top bit
  always @(posedge clk)
  begin
    if (sys_rst || rq_fall || rq_rise)
      rd_started <= 1'b0;
    else if (sclk_fall && rd_load)
      rd_started <= 1'b1;
  end

  // ----------------------------------------------------------------
  // crc check
  // ----------------------------------------------------------------
  wire [`HP_CRC_W-1:0] crc_now;
  reg                  crc_show;

  hp_crc16 u_crc
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clr      (rq_fall),
    .shift_en (rx_bit),
    .bit_in   (si_s),
    .crc      (crc_now)
  );

  // result latched at strobe rise, shown until next strobe fall
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      crc_match <= 1'b0;
      crc_show  <= 1'b0;
    end
    else if (rq_rise)
    begin
      crc_match <= (crc_now == crc_expected_remainder);
      crc_show  <= 1'b1;
    end
    else if (rq_fall)
      crc_show <= 1'b0;
  end

  // ----------------------------------------------------------------
  // dsp bus readout
  // ----------------------------------------------------------------
  reg [`HP_RO_W-1:0] ro_shift;
  reg [4:0]          ro_cnt;
  wire ro_capture = program_readout_instr & (destination_field == `HP_DST_SO);

  // capture, hold while valid, end by si high or 24th rising edge
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ro_shift           <= 24'h00_0000;
      ro_cnt             <= 5'h00;
      readout_data_valid <= 1'b0;
    end
    else if (readout_data_valid)
    begin
      if (si_s)
        readout_data_valid <= 1'b0;
      else if (sclk_rise && ro_cnt == `HP_RO_LAST_BIT)
        readout_data_valid <= 1'b0;
      else
      begin
        if (sclk_rise)
          ro_cnt <= ro_cnt + 5'h01;
        if (sclk_fall && ro_cnt != 5'h00)
          ro_shift <= {ro_shift[`HP_RO_W-2:0], 1'b0};
      end
    end
    else if (ro_capture && !si_s)
    begin
      ro_shift           <= dsp_internal_bus;
      ro_cnt             <= 5'h00;
      readout_data_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // serial output selection
  // ----------------------------------------------------------------
  reg next_so;

  // readout first, then command readback, then check result
  always @*
  begin
    next_so = 1'b0;
    if (readout_data_valid)
      next_so = ro_shift[`HP_RO_W-1];
    else if (rd_started)
      next_so = rd_shift[`HP_RD_W-1];
    else if (crc_show)
      next_so = crc_match;
  end

  always @(posedge clk)
  begin
    if (sys_rst)
      so <= 1'b0;
    else
      so <= next_so;
  end
endmodule // hp_port

/* File: tb/hp_host_model.sv */
/* host pin model for hp_port: sclk, si, strobe.
   assumes a 10 ns clk. */
`timescale 1ns/1ps
module hp_host_model
(
  input  wire clk,
  input  wire so,
  output reg  sclk = 1'b1,
  output reg  si = 1'b0,
  output reg  request_strobe_n = 1'b1
);
  // one 80 ns bit: si set at fall, so taken one clk after the rise
  task bitx(input logic b, output logic r);
    repeat (3) @(posedge clk);
    sclk <= 1'b0;
    si <= b;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    // so moves four clk after a fall, so sample in the high phase
    @(posedge clk);
    r = so;
  endtask
  // a byte, msb first
  task xbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r[i]);
  endtask
  // strobe change once pins settle; si back low
  task strobe(input logic v);
    repeat (8) @(posedge clk);
    request_strobe_n <= v;
    si <= 1'b0;
  endtask
endmodule // hp_host_model

/* File: tb/hp_port_monitor.sv */
/* checker for hp_port pins, bound below.
   assumes host pins slow against clk. */
`timescale 1ns/1ps
module hp_port_monitor
(
  input wire        clk,
  input wire        sys_rst,
  input wire        sclk,
  input wire        si,
  input wire        request_strobe_n,
  input wire [23:0] dsp_internal_bus,
  input wire        program_readout_instr,
  input wire [3:0]  destination_field,
  input wire        so,
  input wire        readout_data_valid,
  input wire [15:0] crc_expected_remainder,
  input wire        crc_match
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // pin relations
  readout_capture_a:
  assert property ((!si) [*3] ##0 (program_readout_instr && destination_field == 4'h1 && !readout_data_valid)
    |=> readout_data_valid) else $error("no capture");
  msb_first_a:
  assert property ($rose(readout_data_valid) |=> so == $past(dsp_internal_bus[23], 2)) else $error("bad msb");
  instr_ignored_a:
  assert property ((readout_data_valid && $stable(sclk)) [*5] ##0 program_readout_instr |=> $stable(so))
    else $error("instr taken");
  si_drop_a:
  assert property (readout_data_valid && $rose(si) |-> ##[1:6] !readout_data_valid) else $error("no drop");
  cmd_so_hold_a:
  assert property (!request_strobe_n && $rose(sclk) |=> $stable(so) [*3]) else $error("so moved");
  check_show_a:
  assert property ((request_strobe_n && !readout_data_valid) [*8] |-> so == crc_match) else $error("bad so");
  match_update_a:
  assert property ($changed(crc_match) |-> request_strobe_n && $past(request_strobe_n, 2)) else $error("early");
  remainder_store_a:
  assert property ($changed(crc_expected_remainder) |-> !request_strobe_n) else $error("bad store");
  // main scenarios reached
  cover property ($rose(readout_data_valid));
  cover property ($rose(crc_match));
  cover property ($fell(crc_match));
endmodule // hp_port_monitor
bind hp_port hp_port_monitor u_mon (.clk, .sys_rst, .sclk, .si, .request_strobe_n, .dsp_internal_bus,
  .program_readout_instr, .destination_field, .so, .readout_data_valid, .crc_expected_remainder, .crc_match);

/* File: tb/hp_port_tb_top.sv */
/* queue-checked bench for hp_port.
   assumes hp_host_model on the host pins. */
`timescale 1ns/1ps
`define HP_CHK(g, e) n_tests++; if ((g) !== (e)) begin mismatches++; $display("unexpected %0t got %h", $time, g); end
module hp_port_tb_top;
  reg          clk, sys_rst, program_readout_instr, b;
  reg   [23:0] dsp_internal_bus, ro, rd;
  reg   [3:0]  destination_field;
  reg   [63:0] ctrl_reg_bank;
  wire         sclk, si, request_strobe_n, so, readout_data_valid, crc_match;
  wire  [15:0] crc_expected_remainder;
  logic [23:0] exp_q[$], got_q[$];
  logic [7:0]  rx[$], q[$];
  int          mismatches = 0, n_tests = 0;
  hp_port dut (.clk, .sys_rst, .sclk, .si, .request_strobe_n, .dsp_internal_bus, .program_readout_instr,
    .destination_field, .ctrl_reg_bank, .so, .readout_data_valid, .crc_expected_remainder, .crc_match);
  hp_host_model host (.clk, .so, .sclk, .si, .request_strobe_n);
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // oldest note against each result
  always @(posedge clk)
    while (got_q.size() > 0)
    begin
      `HP_CHK(got_q[0], exp_q[0])
      got_q.delete(0);
      exp_q.delete(0);
    end
  task note(input logic [23:0] e, input logic [23:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask
  // reference remainder: long division of the zero-padded message by 11021h
  function automatic logic [15:0] crc_ref(input logic [7:0] m[$]);
    logic [16:0] r;
    r = 17'h0_0000;
    foreach (m[i])
      for (int k = 7; k >= 0; k--)
      begin
        r = {r[15:0], m[i][k]};
        if (r[16])
          r = r ^ 17'h1_1021;
      end
    for (int k = 0; k < 16; k++)
    begin
      r = {r[15:0], 1'b0};
      if (r[16])
        r = r ^ 17'h1_1021;
    end
    return r[15:0];
  endfunction
  // one strobe frame, answers in rx
  task frame(input logic [7:0] q[$]);
    logic [7:0] r;
    rx = {};
    host.strobe(1'b0);
    foreach (q[i])
    begin
      host.xbyte(q[i], r);
      rx.push_back(r);
    end
    host.strobe(1'b1);
    repeat (8) @(posedge clk);
  endtask
  // arm remainder, send a frame, look at the result
  task crc_case(input logic [15:0] v, input logic [7:0] q[$], input logic m);
    frame({8'hb6, v[15:8], v[7:0]});
    note(24'(v), 24'(crc_expected_remainder));
    frame(q);
    note({22'h0, m, m}, {22'h0, crc_match, so});
  endtask
  // readout instruction pulse
  task pulse(input logic [23:0] v, input logic [3:0] d);
    repeat (4) @(posedge clk);
    dsp_internal_bus <= v;
    destination_field <= d;
    program_readout_instr <= 1'b1;
    @(posedge clk);
    program_readout_instr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #300us;
    mismatches++;
    summarize();
  end
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    program_readout_instr = 1'b0;
    destination_field = 4'h0;
    dsp_internal_bus = 24'h00_0000;
    ro = 24'($urandom(32'h7442));
    ctrl_reg_bank = {$urandom, $urandom};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    for (int n = 0; n < 8; n++)
    begin
      frame({8'h70 + 8'(2 * n), 8'h00, 8'h00});
      note(24'(ctrl_reg_bank[8 * n + 1 +: 7]), 24'(rx[1][7:1]));
    end
    $display("ctrl read done");
    crc_case(16'h1e51, {8'hd6, 8'hab, 8'hcd}, 1'b1);
    note(24'h00_1e51, {8'h00, rx[1], rx[2]});
    crc_case(16'h0c30, {8'hd2, 8'ha5, 8'ha5}, 1'b1);
    note(24'h00_0000, {8'h00, rx[1], rx[2]});
    crc_case(16'h2297, {8'ha8, 8'h55, 8'h55, 8'h77, 8'h77, 8'haa, 8'haa, 8'h00, 8'h00, 8'hff, 8'hff}, 1'b1);
    crc_case(16'h2297, {8'hd2, 8'ha5, 8'ha4}, 1'b0);
    // random payload behind a byte that no command decodes
    q = {8'h5a, 8'($urandom), 8'($urandom), 8'($urandom)};
    crc_case(crc_ref(q), q, 1'b1);
    // undecoded first byte armed with a wrong remainder must flag a mismatch
    q = {8'ha4, 8'($urandom), 8'($urandom)};
    crc_case(crc_ref(q) ^ 16'h0001, q, 1'b0);
    $display("crc check done");
    ro = 24'($urandom);
    pulse(ro, 4'h2);
    note(24'h00_0000, 24'(readout_data_valid));
    pulse(ro, 4'h1);
    pulse(~ro, 4'h1);
    for (int i = 0; i < 24; i++)
    begin
      host.bitx(1'b0, b);
      rd = {rd[22:0], b};
      if (i == 22)
      begin
        repeat (3) @(posedge clk);
        note(24'h00_0001, 24'(readout_data_valid));
      end
    end
    note(ro, rd);
    repeat (8) @(posedge clk);
    note(24'h00_0000, 24'(readout_data_valid));
    pulse(~ro, 4'h1);
    note(24'h00_0001, 24'(readout_data_valid));
    host.bitx(1'b1, b);
    repeat (8) @(posedge clk);
    note(24'h00_0000, 24'(readout_data_valid));
    host.strobe(1'b1);
    pulse(ro, 4'h1);
    note(24'h00_0001, 24'(readout_data_valid));
    $display("readout done");
    // let the checker drain the last notes before the verdict
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule // hp_port_tb_top
